// *** hw/ccp_cfg.svh ***
/*
  Register offsets, field positions, reset values and response codes
  for the PWM unit.
  Assumes a 32-bit AXI4-Lite slave with byte addresses and one
  aligned word per register.
*/
`ifndef CCP_CFG_SVH
`define CCP_CFG_SVH

`define CCP_OFF_TCTRL     8'h00
`define CCP_OFF_PERIOD    8'h04
`define CCP_OFF_COUNT     8'h08
`define CCP_OFF_DWB       8'h0C
`define CCP_OFF_SHADOW    8'h10
`define CCP_OFF_MCTRL     8'h14
`define CCP_OFF_DIR       8'h18
`define CCP_OFF_STAT      8'h1C
`define CCP_OFF_PORT      8'h20

`define CCP_TC_PS_LSB     0
`define CCP_TC_RUN_BIT    2
`define CCP_TC_POST_LSB   3
`define CCP_MC_MODE_LSB   0
`define CCP_MC_DLOW_LSB   4
`define CCP_ST_FLAG_BIT   0
`define CCP_PT_LATCH_BIT  0
`define CCP_PT_PIN_BIT    1

`define CCP_RST_PERIOD    8'hFF
`define CCP_RST_DIR       1'b1
`define CCP_PWM_MODE_DEF  4'hC

`define CCP_PS_DIV1       2'h0
`define CCP_PS_DIV4       2'h1
`define CCP_LIM_DIV1      6'h03
`define CCP_LIM_DIV4      6'h0F
`define CCP_LIM_DIV16     6'h3F

`define CCP_RESP_OKAY     2'h0
`define CCP_RESP_SLVERR   2'h2

`endif

// *** hw/ccp_pkg.sv ***
/*
  Types of the PWM unit: register selector and the module state.
  Assumes ccp_cfg.svh supplies offsets and reset values.
*/
package ccp_pkg;

  typedef enum logic [3:0] {
    CCP_R_TCTRL, CCP_R_PERIOD, CCP_R_COUNT, CCP_R_DWB, CCP_R_SHADOW,
    CCP_R_MCTRL, CCP_R_DIR, CCP_R_STAT, CCP_R_PORT, CCP_R_NONE
  } ccp_reg_e;

  typedef struct packed {
    logic [1:0]  ps;
    logic        run;
    logic [3:0]  post;
    logic [7:0]  period;
    logic [7:0]  count;
    logic [5:0]  pre;
    logic [7:0]  dwb;
    logic [7:0]  shadow;
    logic [1:0]  latch;
    logic [3:0]  mode;
    logic [1:0]  dlow;
    logic        dir;
    logic        port;
    logic        flag;
    logic        pwm;
    logic        pin_s1;
    logic        pin_s2;
    logic        pin_o;
    logic        pin_oe;
    logic        awready;
    logic        wready;
    logic        haw;
    logic        hw;
    logic [7:0]  awaddr;
    logic [7:0]  wdata;
    logic        wlane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } ccp_state_s;

endpackage : ccp_pkg

// *** hw/ccp_pwm_top.sv ***
/*
  PWM mode of a capture/compare/PWM unit with its timebase, reached
  over an AXI4-Lite slave, driving one two-way pin.
  Assumes sleep_req comes from logic on clk_sys and the pin input
  comes from outside the clock domain.
*/
`include "ccp_cfg.svh"

module ccp_pwm_top #(
  parameter logic [3:0] PWM_MODE = `CCP_PWM_MODE_DEF
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        sleep_req,
  input  wire logic        pwm_pin_i,
  output logic             pwm_pin_o,
  output logic             pwm_pin_oe,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import ccp_pkg::*;

  localparam ccp_state_s ST_RESET = '{
    period:  `CCP_RST_PERIOD,
    dir:     `CCP_RST_DIR,
    awready: 1'b1,
    wready:  1'b1,
    arready: 1'b1,
    default: '0
  };

  ccp_state_s st_reg;
  ccp_state_s st_next;

  function automatic ccp_reg_e decode(input logic [7:0] addr);
    ccp_reg_e r;
    r = CCP_R_NONE;
    unique case ({addr[7:2], 2'b00})
      `CCP_OFF_TCTRL:  r = CCP_R_TCTRL;
      `CCP_OFF_PERIOD: r = CCP_R_PERIOD;
      `CCP_OFF_COUNT:  r = CCP_R_COUNT;
      `CCP_OFF_DWB:    r = CCP_R_DWB;
      `CCP_OFF_SHADOW: r = CCP_R_SHADOW;
      `CCP_OFF_MCTRL:  r = CCP_R_MCTRL;
      `CCP_OFF_DIR:    r = CCP_R_DIR;
      `CCP_OFF_STAT:   r = CCP_R_STAT;
      `CCP_OFF_PORT:   r = CCP_R_PORT;
      default:         r = CCP_R_NONE;
    endcase
    return r;
  endfunction : decode

  // last prescaler count of one timebase step: 4 clocks times ratio
  function automatic logic [5:0] pre_limit(input logic [1:0] ps);
    logic [5:0] lim;
    unique case (ps)
      `CCP_PS_DIV1: lim = `CCP_LIM_DIV1;
      `CCP_PS_DIV4: lim = `CCP_LIM_DIV4;
      default:      lim = `CCP_LIM_DIV16;
    endcase
    return lim;
  endfunction : pre_limit

  // two low timebase bits: clock phase at 1:1, else prescaler bits
  function automatic logic [1:0] ext_bits(input logic [1:0] ps,
                                          input logic [5:0] pre);
    logic [1:0] e;
    unique case (ps)
      `CCP_PS_DIV1: e = pre[1:0];
      `CCP_PS_DIV4: e = pre[3:2];
      default:      e = pre[5:4];
    endcase
    return e;
  endfunction : ext_bits

  function automatic logic [31:0] read_mux(input ccp_reg_e r,
                                           input ccp_state_s s);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (r)
      CCP_R_TCTRL: begin
        d[`CCP_TC_PS_LSB +: 2]   = s.ps;
        d[`CCP_TC_RUN_BIT]       = s.run;
        d[`CCP_TC_POST_LSB +: 4] = s.post;
      end
      CCP_R_PERIOD: d[7:0] = s.period;
      CCP_R_COUNT:  d[7:0] = s.count;
      CCP_R_DWB:    d[7:0] = s.dwb;
      CCP_R_SHADOW: d[7:0] = s.shadow;
      CCP_R_MCTRL: begin
        d[`CCP_MC_MODE_LSB +: 4] = s.mode;
        d[`CCP_MC_DLOW_LSB +: 2] = s.dlow;
      end
      CCP_R_DIR:  d[0] = s.dir;
      CCP_R_STAT: d[`CCP_ST_FLAG_BIT] = s.flag;
      CCP_R_PORT: begin
        d[`CCP_PT_LATCH_BIT] = s.port;
        d[`CCP_PT_PIN_BIT]   = s.pin_s2;
      end
      CCP_R_NONE: d = 32'h0000_0000;
    endcase
    return d;
  endfunction : read_mux

  logic       run_now;
  logic       tick;
  logic       match;
  logic       do_wr;
  logic       flag_clr;
  logic       pwm_mode;
  logic       pwm_mode_next;
  logic [9:0] tb_next;
  ccp_reg_e   wr_sel;
  ccp_reg_e   rd_sel;

  always_comb begin
    st_next  = st_reg;
    match    = 1'b0;
    tick     = 1'b0;
    flag_clr = 1'b0;
    tb_next  = 10'h000;
    pwm_mode = (st_reg.mode == PWM_MODE);
    wr_sel   = decode(st_reg.awaddr);
    rd_sel   = decode(s_axi_araddr);
    do_wr    = st_reg.haw && st_reg.hw && !st_reg.bvalid;

    // pin input synchroniser
    st_next.pin_s1 = pwm_pin_i;
    st_next.pin_s2 = st_reg.pin_s1;

    // read channel
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid  = 1'b0;
      st_next.arready = 1'b1;
    end
    if (st_reg.arready && s_axi_arvalid) begin
      st_next.arready = 1'b0;
      st_next.rvalid  = 1'b1;
      st_next.rdata   = read_mux(rd_sel, st_reg);
      st_next.rresp   = (rd_sel == CCP_R_NONE) ? `CCP_RESP_SLVERR
                                               : `CCP_RESP_OKAY;
    end

    // write channels, taken in either order
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid  = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready  = 1'b1;
    end
    if (st_reg.awready && s_axi_awvalid) begin
      st_next.awready = 1'b0;
      st_next.haw     = 1'b1;
      st_next.awaddr  = s_axi_awaddr;
    end
    if (st_reg.wready && s_axi_wvalid) begin
      st_next.wready = 1'b0;
      st_next.hw     = 1'b1;
      st_next.wdata  = s_axi_wdata[7:0];
      st_next.wlane0 = s_axi_wstrb[0];
    end

    // timebase: sleep freezes prescaler and count, postscaler not used
    run_now = st_reg.run && !sleep_req;
    if (run_now) begin
      if (st_reg.pre == pre_limit(st_reg.ps)) begin
        st_next.pre = 6'h00;
        tick        = 1'b1;
      end else begin
        st_next.pre = st_reg.pre + 6'h01;
      end
      if (tick) begin
        if (st_reg.count == st_reg.period) begin
          st_next.count = 8'h00;
          match         = 1'b1;
        end else begin
          st_next.count = st_reg.count + 8'h01;
        end
      end
    end

    // new duty only at a period boundary
    if (match) begin
      st_next.shadow = st_reg.dwb;
      st_next.latch  = st_reg.dlow;
    end

    // output level: set at period start unless new duty is zero, cleared at duty match
    tb_next = {st_next.count, ext_bits(st_reg.ps, st_next.pre)};
    if (!pwm_mode) begin
      st_next.pwm = 1'b0;
    end else if (run_now) begin
      if (match) begin
        st_next.pwm = ({st_reg.dwb, st_reg.dlow} != 10'h000);
      end else if (tb_next == {st_reg.shadow, st_reg.latch}) begin
        st_next.pwm = 1'b0;
      end
    end

    // register writes, byte lane 0 carries every field
    if (do_wr) begin
      st_next.haw    = 1'b0;
      st_next.hw     = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = (wr_sel == CCP_R_NONE) ? `CCP_RESP_SLVERR
                                              : `CCP_RESP_OKAY;
      if (st_reg.wlane0) begin
        unique case (wr_sel)
          CCP_R_TCTRL: begin
            st_next.ps   = st_reg.wdata[`CCP_TC_PS_LSB +: 2];
            st_next.run  = st_reg.wdata[`CCP_TC_RUN_BIT];
            st_next.post = st_reg.wdata[`CCP_TC_POST_LSB +: 4];
          end
          CCP_R_PERIOD: st_next.period = st_reg.wdata;
          CCP_R_COUNT:  st_next.count  = st_reg.wdata;
          CCP_R_DWB:    st_next.dwb    = st_reg.wdata;
          CCP_R_SHADOW: begin
            if (!pwm_mode) begin
              st_next.shadow = st_reg.wdata;
            end
          end
          CCP_R_MCTRL: begin
            st_next.mode = st_reg.wdata[`CCP_MC_MODE_LSB +: 4];
            st_next.dlow = st_reg.wdata[`CCP_MC_DLOW_LSB +: 2];
          end
          CCP_R_DIR:  st_next.dir  = st_reg.wdata[0];
          CCP_R_STAT: flag_clr     = st_reg.wdata[`CCP_ST_FLAG_BIT];
          CCP_R_PORT: st_next.port = st_reg.wdata[`CCP_PT_LATCH_BIT];
          CCP_R_NONE: st_next.port = st_reg.port;
        endcase
      end
    end

    // write-one-to-clear, a match in the same cycle wins
    st_next.flag = (st_reg.flag && !flag_clr) || match;

    // pin: direction gates the driver, non-PWM modes give port latch
    pwm_mode_next  = (st_next.mode == PWM_MODE);
    st_next.pin_oe = !st_next.dir;
    st_next.pin_o  = pwm_mode_next ? st_next.pwm : st_next.port;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pwm_pin_o     = st_reg.pin_o;
  assign pwm_pin_oe    = st_reg.pin_oe;
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready  = st_reg.wready;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;
  assign s_axi_rvalid  = st_reg.rvalid;

endmodule : ccp_pwm_top

// *** testbench/ccp_pwm_checker.sv ***
/*
  Concurrent checks on the ports of the PWM unit.
  Assumes a bind to ccp_pwm_top from the bench top file.
*/
module ccp_pwm_checker (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        sleep_req,
  input wire logic        pwm_pin_o,
  input wire logic        pwm_pin_oe,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write not answered two cycles after take");
  a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read not answered one cycle after take");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_wr_busy: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while response pending");
  a_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read channel ready while data pending");
  a_sleep_freeze: assert property (sleep_req |=>
    $stable(pwm_pin_o) && $stable(pwm_pin_oe))
    else $error("pin moved during sleep");
  a_rst_quiet: assert property ($fell(reset) |->
    !pwm_pin_oe && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not at reset values after reset");
endmodule : ccp_pwm_checker

// *** testbench/ccp_pwm_mode_generator_tb.sv ***
/*
  Self-checking bench for the PWM unit, driven over AXI4-Lite.
  Assumes ccp_pwm_top with its default mode code, clk_sys at 40 MHz.
*/
`include "ccp_cfg.svh"
module ccp_pwm_mode_generator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, reset, sleep_req, pwm_pin_i, pwm_pin_o, pwm_pin_oe;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, e;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          miscompares, cmp_count, hi, per, h;

  ccp_pwm_top dut_u (.clk_sys, .reset, .sleep_req, .pwm_pin_i, .pwm_pin_o,
    .pwm_pin_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string n, input logic [31:0] s, x);
    cmp_count++;
    if (s !== x) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // one AXI4-Lite write (w=1) or read (w=0); answer in r and d
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] v);
    bit b;
    b = 1'b0;
    @(posedge clk_sys);
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    while (!b) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (w ? s_axi_bvalid : s_axi_rvalid) begin
        b = 1'b1;
        r = w ? s_axi_bresp : s_axi_rresp;
        d = s_axi_rdata;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
      end
    end
  endtask : bus

  // high cycles and period cycles of one whole pulse
  task automatic meas();
    logic p;
    p = 1'b1;
    hi = 1;
    per = 1;
    do @(posedge clk_sys); while (pwm_pin_o !== 1'b0);
    do @(posedge clk_sys); while (pwm_pin_o !== 1'b1);
    forever begin
      @(posedge clk_sys);
      if (p === 1'b0 && pwm_pin_o === 1'b1) break;
      p = pwm_pin_o;
      per++;
      hi += int'(p === 1'b1);
    end
  endtask : meas

  task automatic cnt();
    h = 0;
    repeat (32) begin
      @(posedge clk_sys);
      h += int'(pwm_pin_o === 1'b1);
    end
  endtask : cnt

  task automatic t_reset();
    bus(0, `CCP_OFF_PERIOD, 0);
    chk("period_limit", d, 32'hFF);
    bus(0, `CCP_OFF_DIR, 0);
    chk("pin_direction", d, 32'h1);
    bus(0, 8'h40, 0);
    chk("unmapped rresp", 32'(r), 32'h2);
  endtask : t_reset

  task automatic t_setup();
    bus(1, `CCP_OFF_PERIOD, 32'h3);
    bus(1, `CCP_OFF_MCTRL, 32'h2C);
    bus(1, `CCP_OFF_DWB, 32'h1);
    bus(1, `CCP_OFF_STAT, 32'h1);
    bus(1, `CCP_OFF_TCTRL, 32'h4);
    do bus(0, `CCP_OFF_STAT, 0); while (d[0] !== 1'b1);
    chk("oe while input", 32'(pwm_pin_oe), 32'h0);
    bus(1, `CCP_OFF_DIR, 32'h0);
    chk("oe while output", 32'(pwm_pin_oe), 32'h1);
  endtask : t_setup

  task automatic t_prescale();
    int m[3] = '{1, 4, 16};
    for (int s = 0; s < 3; s++) begin
      bus(1, `CCP_OFF_TCTRL, 32'h4 | s);
      meas();
      meas();
      chk("period", per, 16 * m[s]);
      chk("high time", hi, 6 * m[s]);
    end
  endtask : t_prescale

  task automatic t_buffer();
    bus(1, `CCP_OFF_DWB, 32'h2);
    bus(0, `CCP_OFF_SHADOW, 0);
    chk("shadow before match", d, 32'h1);
    bus(1, `CCP_OFF_SHADOW, 32'h55);
    bus(0, `CCP_OFF_SHADOW, 0);
    chk("shadow after write", d, 32'h1);
    meas();
    chk("new high time", hi, 160);
    bus(0, `CCP_OFF_SHADOW, 0);
    chk("shadow after match", d, 32'h2);
  endtask : t_buffer

  task automatic t_edges();
    bus(1, `CCP_OFF_TCTRL, 32'h4);
    bus(1, `CCP_OFF_DWB, 32'h0);
    bus(1, `CCP_OFF_MCTRL, 32'h0C);
    // prescale switch stretches one period; wait for a match after it
    bus(1, `CCP_OFF_STAT, 32'h1);
    do bus(0, `CCP_OFF_STAT, 0); while (d[0] !== 1'b1);
    cnt();
    chk("zero duty high", h, 0);
    bus(1, `CCP_OFF_DWB, 32'h10);
    repeat (40) @(posedge clk_sys);
    cnt();
    chk("long duty high", h, 32);
  endtask : t_edges

  task automatic t_sleep();
    sleep_req <= 1'b1;
    bus(0, `CCP_OFF_COUNT, 0);
    e = d;
    repeat (20) @(posedge clk_sys);
    bus(0, `CCP_OFF_COUNT, 0);
    chk("count in sleep", d, e);
    sleep_req <= 1'b0;
  endtask : t_sleep

  task automatic t_release();
    bus(1, `CCP_OFF_PORT, 32'h1);
    bus(1, `CCP_OFF_MCTRL, 32'h0);
    repeat (3) @(posedge clk_sys);
    chk("pin from latch 1", 32'(pwm_pin_o), 32'h1);
    bus(1, `CCP_OFF_PORT, 32'h0);
    repeat (3) @(posedge clk_sys);
    chk("pin from latch 0", 32'(pwm_pin_o), 32'h0);
    bus(0, `CCP_OFF_PORT, 0);
    chk("port read", d, 32'h2);
    pwm_pin_i <= 1'b0;
    repeat (3) @(posedge clk_sys);
    bus(0, `CCP_OFF_PORT, 0);
    chk("port pin low", d, 32'h0);
    bus(1, 8'h40, 32'h1);
    chk("unmapped bresp", 32'(r), 32'h2);
  endtask : t_release

  task automatic t_rerst();
    chk("oe before reset", 32'(pwm_pin_oe), 32'h1);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    chk("oe in reset", 32'(pwm_pin_oe), 32'h0);
    bus(0, `CCP_OFF_PERIOD, 0);
    chk("period after reset", d, 32'hFF);
  endtask : t_rerst

  initial begin
    {reset, s_axi_wstrb, pwm_pin_i} = 6'h3F;
    {sleep_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    s_axi_wdata = 32'h0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_setup();
    t_prescale();
    t_buffer();
    t_edges();
    t_sleep();
    t_release();
    t_rerst();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    finish_test();
  end
endmodule : ccp_pwm_mode_generator_tb

bind ccp_pwm_top ccp_pwm_checker chk_u (.clk_sys, .reset, .sleep_req,
  .pwm_pin_o, .pwm_pin_oe, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
